// ### test/qrds_analog_model.sv
// Purpose: Comparator and transformer model facing the drive sequencer
// Assumes: Delays in clock cycles; zero disables that event
// Notes:   Ringing repeats every 400 cycles, so the timeout never fires while it lasts
`timescale 1ns/1ps
`default_nettype none
module qrds_analog_model (
  // Clock and gate
  input  wire logic        clk,
  input  wire logic        gate,
  // Event delays
  input  wire logic [15:0] cs_dly,
  input  wire logic [15:0] dm_dly,
  // Comparator levels
  output logic             cs_trip,
  output logic             demag_low
);
  int on_cnt = 0;
  int off_cnt = 0;

  always @(posedge clk)
  begin
    on_cnt    <= gate ? on_cnt + 1 : 0;
    off_cnt   <= gate ? 0 : off_cnt + 1;
    cs_trip   <= gate && cs_dly != 0 && on_cnt + 1 >= int'(cs_dly);
    demag_low <= !gate && dm_dly != 0 && off_cnt >= int'(dm_dly)
                 && (off_cnt - int'(dm_dly)) % 400 < 20;
  end
endmodule : qrds_analog_model
`default_nettype wire

// ### test/qrds_sequencer_assertions.sv
// Purpose: Port-level checks of the drive sequencer
// Assumes: Three cycles from comparator change to output change
// Notes:   Windows allow for the input synchroniser
`timescale 1ns/1ps
`default_nettype none
module qrds_sequencer_assertions #(
  parameter int unsigned MAXON_CYCLES = qrds_pkg::MAXON_CYC,
  parameter int unsigned SOFT_CYCLES  = qrds_pkg::SOFT_CYC
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Watched ports
  input wire qrds_pkg::qrds_cmp_s    cmp,
  input wire logic                   gate_drive_output,
  input wire logic                   vcc_clamp_en,
  input wire logic                   latchoff_sink_en,
  input wire logic [7:0]             soft_level,
  input wire qrds_pkg::qrds_status_s status
);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] rise_cnt;
  logic        g;
  assign g = gate_drive_output;

  always_ff @(posedge clk)
    hi_cnt <= (rst || !g) ? 16'h0000 : hi_cnt + 16'h0001;
  // Saturate so long idle spells never wrap into a false short gap
  always_ff @(posedge clk)
    lo_cnt <= (rst || g) ? 16'h0000 : (&lo_cnt ? lo_cnt : lo_cnt + 16'h0001);
  always_ff @(posedge clk)
    rise_cnt <= rst ? 16'hffff
              : ($rose(g) ? 16'h0001 : (&rise_cnt ? rise_cnt : rise_cnt + 16'h0001));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_cs_clear: assert property (g && $rose(cmp.cs_trip) |-> ##[1:4] !g)
    else $error("gate not cleared by current trip");
  chk_maxon_limit: assert property (hi_cnt <= MAXON_CYCLES + 1)
    else $error("gate high too long");
  chk_maxon_stop: assert property (hi_cnt == MAXON_CYCLES |-> ##[0:3]
    (status.state == qrds_pkg::QRDS_LATCHOFF && status.maxon_fault))
    else $error("no latch-off after maximum on time");
  chk_blank_time: assert property ($rose(g) |-> lo_cnt >= 750)
    else $error("restart inside blanking");
  chk_period_min: assert property ($rose(g) |-> rise_cnt >= 2000)
    else $error("period shorter than clamp");
  chk_skip_stop: assert property (status.state == qrds_pkg::QRDS_RUN
    && $rose(cmp.feedback_below_skip) |-> ##[1:5]
    (!g && status.skip_hold && status.setpoint_clamp))
    else $error("skip did not stop pulses");
  chk_skip_hold: assert property (status.skip_hold && $past(status.skip_hold) |-> !g)
    else $error("pulse during skip hold");
  // Release is seen four edges after the comparator sample; leaving RUN is excluded
  chk_hyst_release: assert property ($fell(status.skip_hold)
    && status.state == qrds_pkg::QRDS_RUN
    |-> $past(cmp.feedback_above_release, 4) && !$past(cmp.feedback_below_skip, 4))
    else $error("skip released below hysteresis");
  // Restart pulse leads the registered hold flag by one cycle
  chk_soft_restart: assert property ($fell(status.skip_hold)
    && status.state == qrds_pkg::QRDS_RUN
    |-> $past(status.soft_restart) && soft_level == 8'h00)
    else $error("soft-start not restarted");
  chk_uv_latchoff: assert property (status.state == qrds_pkg::QRDS_RUN
    && $fell(cmp.vcc_above_off)
    |-> ##[2:6] (status.state == qrds_pkg::QRDS_LATCHOFF && !g && latchoff_sink_en))
    else $error("undervoltage did not stop pulses");
  // Clamp drops one cycle before the registered state leaves LATCHED
  chk_latch_clamp: assert property (status.state == qrds_pkg::QRDS_LATCHED
    |-> !g && (vcc_clamp_en || $past(cmp.vcc_below_reset, 3)))
    else $error("latched without clamp");
  chk_reset_quiet: assert property ($past(rst) |-> !g && !vcc_clamp_en
    && soft_level == 8'h00 && status == '0)
    else $error("outputs active after reset");

  cover property ($rose(g));
  cover property ($fell(status.skip_hold));
  cover property (status.state == qrds_pkg::QRDS_LATCHED);
  cover property ($rose(status.maxon_fault));
endmodule : qrds_sequencer_assertions

bind qrds_sequencer qrds_sequencer_assertions #(.MAXON_CYCLES(MAXON_CYCLES),
  .SOFT_CYCLES(SOFT_CYCLES)) u_chk (.clk(clk), .rst(rst), .cmp(cmp),
  .gate_drive_output(gate_drive_output), .vcc_clamp_en(vcc_clamp_en),
  .latchoff_sink_en(latchoff_sink_en), .soft_level(soft_level), .status(status));
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench of the drive sequencer
// Assumes: Shortened maximum on time and soft-start
// Notes:   Restart instants come from a valley model with a queue
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   clk;
  logic                   rst;
  qrds_pkg::qrds_cmp_s    c;
  qrds_pkg::qrds_cmp_s    cmp_in;
  logic                   cs_w;
  logic                   dm_w;
  logic [15:0]            cs_dly;
  logic [15:0]            dm_dly;
  logic                   gate;
  logic                   clamp;
  logic                   sink;
  logic [7:0]             lvl;
  qrds_pkg::qrds_status_s st;
  int                     n_fail;
  int                     cmp_count;
  int                     cyc;
  int                     n;
  int                     t;
  int                     exp_q[$];

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always_comb
  begin
    cmp_in           = c;
    cmp_in.cs_trip   = cs_w;
    cmp_in.demag_low = dm_w;
  end

  qrds_sequencer #(.MAXON_CYCLES(40), .SOFT_CYCLES(512)) uut (.clk(clk), .rst(rst),
    .cmp(cmp_in), .gate_drive_output(gate), .vcc_clamp_en(clamp),
    .latchoff_sink_en(sink), .soft_level(lvl), .status(st));
  qrds_analog_model pm (.clk(clk), .gate(gate), .cs_dly(cs_dly), .dm_dly(dm_dly),
    .cs_trip(cs_w), .demag_low(dm_w));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic wait_gate(input logic v, input int lim);
    n = 0;
    while (gate !== v && n < lim)
    begin
      step(1);
      n++;
    end
  endtask : wait_gate

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    c = '0;
    cs_dly = 16'd10;
    dm_dly = 16'd0;
    rst = 1'b1;
    void'($urandom(32'h20b920b2));
    step(2);
    rst = 1'b0;
    step(100);
    chk("idle", {gate, lvl, st}, 0);
    c.vcc_above_on = 1'b1;
    c.vcc_above_off = 1'b1;
    c.feedback_above_release = 1'b1;
    wait_gate(1'b1, 2200);
    chk("first rise", n >= 2000, 1);
    chk("ramp", {lvl, st.soft_active}, 9'h1fe);
    // Ringing starts in blanking, mid-period and at a random valley
    for (int i = 0; i < 3; i++)
    begin
      dm_dly = (i == 0) ? 16'd100 : ((i == 1) ? 16'd800 : 16'(420 + $urandom % 150));
      wait_gate(1'b0, 100);
      chk("on time", n >= 11 && n <= 16, 1);
      t = dm_dly;
      while (t < 750 || t + n < 2000)
        t = t + 400;
      exp_q.push_back(t);
      wait_gate(1'b1, 4000);
      t = exp_q.pop_front();
      chk("off time", n >= t && n <= t + 6, 1);
    end
    c.feedback_above_release = 1'b0;
    c.feedback_below_skip = 1'b1;
    wait_gate(1'b0, 8);
    step(2);
    chk("skip", {st.skip_hold, st.setpoint_clamp}, 2'b11);
    c.feedback_below_skip = 1'b0;
    step(3000);
    chk("held", {gate, st.skip_hold}, 2'b01);
    c.feedback_above_release = 1'b1;
    step(5);
    chk("burst", {st.skip_hold, lvl < 8'h04, st.soft_active}, 3'b011);
    wait_gate(1'b1, 420);
    chk("valley start", n < 420, 1);
    dm_dly = 16'd0;
    c.feedback_above_release = 1'b0;
    c.feedback_below_skip = 1'b1;
    step(2600);
    chk("timeout", st.timeout_ready, 1);
    c.feedback_below_skip = 1'b0;
    c.feedback_above_release = 1'b1;
    wait_gate(1'b1, 10);
    chk("timeout start", n < 10, 1);
    cs_dly = 16'd0;
    wait_gate(1'b0, 100);
    chk("max on", n >= 38 && n <= 42, 1);
    step(2);
    chk("maxon stop", {st.state == qrds_pkg::QRDS_LATCHOFF, st.maxon_fault, sink}, 7);
    for (int k = 0; k < 2; k++)
    begin
      c.vcc_above_on = 1'b0;
      c.vcc_below_restart = 1'b1;
      step(6);
      c.vcc_below_restart = 1'b0;
      c.vcc_above_on = 1'b1;
      step(6);
      chk("recover", {st.state == qrds_pkg::QRDS_RUN, st.maxon_fault}, 2'b10);
      if (k == 0)
      begin
        wait_gate(1'b1, 2200);
        c.fault_timer_run = 1'b1;
        c.vcc_above_off = 1'b0;
        wait_gate(1'b0, 8);
        step(2);
        chk("uv", {n < 8, st.state == qrds_pkg::QRDS_LATCHOFF}, 2'b11);
        c.vcc_above_off = 1'b1;
        c.fault_timer_run = 1'b0;
      end
    end
    // Expired fault timer in RUN takes the latch-off path
    c.fault_timer_done = 1'b1;
    step(6);
    chk("fault stop", {st.state, sink}, 3'b101);
    c.fault_timer_done = 1'b0;
    c.latch_req = 1'b1;
    step(6);
    c.latch_req = 1'b0;
    step(20);
    chk("latched", {st.state == qrds_pkg::QRDS_LATCHED, clamp, gate}, 3'b110);
    c.vcc_above_on = 1'b0;
    c.vcc_below_reset = 1'b1;
    step(6);
    chk("unlatch", {st.state == qrds_pkg::QRDS_OFF, clamp}, 2'b10);
    end_sim();
  end
endmodule : tb
`default_nettype wire

// ### verilog/qrds_pkg.sv
// Purpose: Shared constants, states and signal groups of the drive sequencer
// Assumes: 250 MHz system clock; comparator levels are produced in the analog front end
// Notes:   Times are kept in ns; cycle counts are derived from the clock rate
package qrds_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 250;

  // Interval figures in nanoseconds
  localparam int unsigned PERIOD_NS  = 8000;
  localparam int unsigned BLANK_NS   = 3000;
  localparam int unsigned MAXON_NS   = 50000;
  localparam int unsigned TIMEOUT_NS = 8000;
  localparam int unsigned SOFT_NS    = 5000000;

  // Least times round up to whole cycles
  localparam int unsigned PERIOD_CYC  = (PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_CYC   = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAXON_CYC   = (MAXON_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SOFT_CYC    = (SOFT_NS / 1000) * CLK_MHZ;

  // Soft-start ramp resolution, reset and full-scale values
  localparam int unsigned SS_BITS       = 8;
  localparam logic [7:0]  SS_LEVEL_RST  = 8'h00;
  localparam logic [7:0]  SS_LEVEL_FULL = 8'hff;

  // Sequencer states
  typedef enum logic [1:0] {
    QRDS_OFF      = 2'b00,
    QRDS_RUN      = 2'b01,
    QRDS_LATCHOFF = 2'b10,
    QRDS_LATCHED  = 2'b11
  } qrds_state_e;

  // Comparator levels from the analog front end, active high
  typedef struct packed {
    logic cs_trip;            // Sensed current at feedback setpoint
    logic demag_low;          // Auxiliary winding below 45 mV
    logic feedback_below_skip;     // Feedback at or under the skip level
    logic feedback_above_release;  // Feedback above skip level plus hysteresis
    logic vcc_above_on;       // Supply reached start level
    logic vcc_above_off;      // Supply above minimum operating level
    logic vcc_below_restart;  // Supply dropped to latch-off restart level
    logic vcc_below_reset;    // Supply under 4 V, latch release
    logic latch_req;          // External latch or overvoltage request
    logic fault_timer_run;    // Fault timer counting
    logic fault_timer_done;   // Fault timer expired
  } qrds_cmp_s;

  // Status outputs
  typedef struct packed {
    qrds_state_e state;
    logic        skip_hold;       // Pulses blanked by skip
    logic        setpoint_clamp;  // Peak setpoint held at skip level
    logic        soft_active;     // Soft-start ramp in progress
    logic        soft_restart;    // One-cycle pulse on ramp restart
    logic        maxon_fault;     // Sticky until next startup
    logic        timeout_ready;   // Timeout permission level
  } qrds_status_s;

endpackage : qrds_pkg

// ### verilog/qrds_sequencer.sv
// Purpose: Switching-cycle sequencer of a quasi-resonant flyback controller
// Assumes: One clock; comparator inputs are asynchronous and resynchronised here
// Notes:   Ramp level is a digital code for the analog peak limit
`timescale 1ns/1ps
`default_nettype none

module qrds_sequencer #(
  parameter int unsigned MAXON_CYCLES = qrds_pkg::MAXON_CYC,
  parameter int unsigned SOFT_CYCLES  = qrds_pkg::SOFT_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Comparator levels
  input  wire qrds_pkg::qrds_cmp_s  cmp,
  // Power stage
  output logic                      gate_drive_output,
  output logic                      vcc_clamp_en,
  output logic                      latchoff_sink_en,
  // Peak limit and status
  output logic [7:0]                soft_level,
  output qrds_pkg::qrds_status_s    status
);

  localparam int unsigned PW = $clog2(qrds_pkg::PERIOD_CYC + 1);
  localparam int unsigned BW = $clog2(qrds_pkg::BLANK_CYC + 1);
  localparam int unsigned MW = $clog2(MAXON_CYCLES + 1);
  localparam int unsigned OW = $clog2(qrds_pkg::TIMEOUT_CYC + 1);
  localparam int unsigned STEP_CYC = (SOFT_CYCLES >> qrds_pkg::SS_BITS) > 0 ?
                                     (SOFT_CYCLES >> qrds_pkg::SS_BITS) : 1;
  localparam int unsigned SW = $clog2(STEP_CYC + 1);

  localparam logic [PW-1:0] PERIOD_END  = PW'(qrds_pkg::PERIOD_CYC);
  localparam logic [BW-1:0] BLANK_END   = BW'(qrds_pkg::BLANK_CYC);
  localparam logic [MW-1:0] MAXON_END   = MW'(MAXON_CYCLES);
  localparam logic [OW-1:0] TIMEOUT_END = OW'(qrds_pkg::TIMEOUT_CYC);
  localparam logic [SW-1:0] STEP_END    = SW'(STEP_CYC - 1);

  // Synchroniser and edge history
  qrds_pkg::qrds_cmp_s cmp_meta;
  qrds_pkg::qrds_cmp_s cmp_s;
  logic                demag_prev;

  // Sequencer state and timers
  qrds_pkg::qrds_state_e state;
  logic                  skip_hold;
  logic [PW-1:0]         period_cnt;
  logic [BW-1:0]         blank_cnt;
  logic [MW-1:0]         on_cnt;
  logic [OW-1:0]         timeout_cnt;
  logic [SW-1:0]         step_cnt;
  logic                  maxon_fault;

  // Combinational terms
  logic running;
  logic demag_edge;
  logic period_done;
  logic blanking;
  logic timeout_ready;
  logic maxon_hit;
  logic skip_release;
  logic burst_start;
  logic set_drive;
  logic clear_drive;

  // Two flops; nothing but the second stage looks at the first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmp_meta <= '0;
      cmp_s    <= '0;
    end
    else
    begin
      cmp_meta <= cmp;
      cmp_s    <= cmp_meta;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      demag_prev <= 1'b0;
    else
      demag_prev <= cmp_s.demag_low;
  end

  assign running       = (state == qrds_pkg::QRDS_RUN);
  assign demag_edge    = cmp_s.demag_low & ~demag_prev;
  assign period_done   = (period_cnt == PERIOD_END);
  assign blanking      = (blank_cnt != '0);
  assign timeout_ready = (timeout_cnt == TIMEOUT_END);
  assign maxon_hit     = gate_drive_output & (on_cnt == MAXON_END);
  assign skip_release  = skip_hold & cmp_s.feedback_above_release;

  // Only a burst restart or a fresh startup retriggers the ramp
  assign burst_start = (running & skip_release) |
                       ((state == qrds_pkg::QRDS_OFF) & cmp_s.vcc_above_on);

  // Edge outside blanking and after the period clamp, or the timeout grant
  assign set_drive = running & ~gate_drive_output & ~skip_hold & ~blanking &
                     period_done &
                     ((demag_edge & ~blanking) | timeout_ready);

  assign clear_drive = gate_drive_output &
                       (cmp_s.cs_trip |
                        skip_hold | ~running | maxon_hit);

  // Main sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
      state <= qrds_pkg::QRDS_OFF;
    else
    begin
      case (state)
        qrds_pkg::QRDS_OFF:
        begin
          if (cmp_s.latch_req)
            state <= qrds_pkg::QRDS_LATCHED;
          else if (cmp_s.vcc_above_on)
            state <= qrds_pkg::QRDS_RUN;
        end
        qrds_pkg::QRDS_RUN:
        begin
          if (cmp_s.latch_req)
            state <= qrds_pkg::QRDS_LATCHED;
          else if (~cmp_s.vcc_above_off)
            state <= qrds_pkg::QRDS_LATCHOFF;
          else if (cmp_s.fault_timer_done | maxon_hit)
            state <= qrds_pkg::QRDS_LATCHOFF;
        end
        qrds_pkg::QRDS_LATCHOFF:
        begin
          if (cmp_s.latch_req)
            state <= qrds_pkg::QRDS_LATCHED;
          else if (cmp_s.vcc_below_restart)
            state <= qrds_pkg::QRDS_OFF;
        end
        qrds_pkg::QRDS_LATCHED:
        begin
          if (cmp_s.vcc_below_reset)
            state <= qrds_pkg::QRDS_OFF;
        end
        default:
          state <= qrds_pkg::QRDS_OFF;
      endcase
    end
  end

  // Drive flip-flop; a clear wins over a set in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      gate_drive_output <= 1'b0;
    else if (clear_drive)
      gate_drive_output <= 1'b0;
    else if (set_drive)
      gate_drive_output <= 1'b1;
  end

  // Skip hold with hysteresis; below-skip wins over release
  always_ff @(posedge clk)
  begin
    if (rst | ~running)
      skip_hold <= 1'b0;
    else if (cmp_s.feedback_below_skip)
      skip_hold <= 1'b1;
    else if (cmp_s.feedback_above_release)
      skip_hold <= 1'b0;
  end

  // Period clamp, restarted at each gate rising edge
  always_ff @(posedge clk)
  begin
    if (rst | ~running)
      period_cnt <= PERIOD_END;
    else if (set_drive)
      period_cnt <= '0;
    else if (~period_done)
      period_cnt <= period_cnt + PW'(1);
  end

  // Leakage blanking after every turn-off in RUN
  always_ff @(posedge clk)
  begin
    if (rst | ~running)
      blank_cnt <= '0;
    else if (clear_drive)
      blank_cnt <= BLANK_END;
    else if (blanking)
      blank_cnt <= blank_cnt - BW'(1);
  end

  // On-time guard
  always_ff @(posedge clk)
  begin
    if (rst | ~gate_drive_output)
      on_cnt <= '0;
    else if (on_cnt != MAXON_END)
      on_cnt <= on_cnt + MW'(1);
  end

  // Fault flag stays up through the restart until the next startup
  always_ff @(posedge clk)
  begin
    if (rst)
      maxon_fault <= 1'b0;
    else if (maxon_hit)
      maxon_fault <= 1'b1;
    else if (burst_start & ~running)
      maxon_fault <= 1'b0;
  end

  // Timeout generator; cleared by any crossing, even while blanking
  always_ff @(posedge clk)
  begin
    if (rst | ~running | gate_drive_output | demag_edge)
      timeout_cnt <= '0;
    else if (~timeout_ready)
      timeout_cnt <= timeout_cnt + OW'(1);
  end

  // Soft-start ramp, one code step per prescaler wrap
  always_ff @(posedge clk)
  begin
    if (rst | ~running | burst_start)
      step_cnt <= '0;
    else if (step_cnt == STEP_END)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + SW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst | ~running | burst_start)
      soft_level <= qrds_pkg::SS_LEVEL_RST;
    else if ((step_cnt == STEP_END) && (soft_level != qrds_pkg::SS_LEVEL_FULL))
      soft_level <= soft_level + 8'h01;
  end

  // Supply clamp and latch-off sink
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vcc_clamp_en     <= 1'b0;
      latchoff_sink_en <= 1'b0;
    end
    else
    begin
      vcc_clamp_en     <= (state == qrds_pkg::QRDS_LATCHED) & ~cmp_s.vcc_below_reset;
      latchoff_sink_en <= (state == qrds_pkg::QRDS_LATCHOFF) & ~cmp_s.vcc_below_restart;
    end
  end

  // Registered status
  always_ff @(posedge clk)
  begin
    if (rst)
      status <= '0;
    else
    begin
      status.state          <= state;
      status.skip_hold      <= skip_hold;
      status.setpoint_clamp <= running & skip_hold;
      status.soft_active    <= running & (soft_level != qrds_pkg::SS_LEVEL_FULL);
      status.soft_restart   <= burst_start;
      status.maxon_fault    <= maxon_fault;
      status.timeout_ready  <= timeout_ready;
    end
  end

endmodule : qrds_sequencer

`default_nettype wire
